// *** hw/nbi_pkg.sv ***
package nbi_pkg;

    // register byte addresses on the apb port
    localparam int NBI_ADDR_W = 12;
    localparam logic [11:0] NBI_SA_ISR_OFS = 12'h0B0C;
    localparam logic [11:0] NBI_SA_IER_OFS = 12'h0B10;
    localparam logic [11:0] NBI_EXZ_SR_OFS = 12'h0B14;
    localparam logic [11:0] NBI_EXZ_ER_OFS = 12'h0B18;

    // sa interrupt status and enable share one bit layout
    localparam int NBI_SA6_ONES_BIT = 7;
    localparam int NBI_SA6_E_BIT = 6;
    localparam int NBI_SA6_C_BIT = 5;
    localparam int NBI_SA6_A_BIT = 4;
    localparam int NBI_SA6_8_BIT = 3;
    localparam int NBI_SA6_2X_BIT = 2;
    localparam int NBI_SA6_UNL_BIT = 1;
    localparam int NBI_SA6_ZERO_BIT = 0;
    localparam logic [7:0] NBI_SA6_UNL_MASK = 8'h02;

    // excessive zero status and enable layout
    localparam int NBI_NAT7_STATE_BIT = 5;
    localparam int NBI_NAT7_CHG_BIT = 1;
    localparam int NBI_ZRUN_CHG_BIT = 0;
    localparam logic [7:0] NBI_EXZ_STICKY_MASK = 8'h03;
    localparam logic [7:0] NBI_EXZ_ER_MASK = 8'h03;

    // national bit 6 patterns
    localparam logic [3:0] NBI_PAT_ONES = 4'hF;
    localparam logic [3:0] NBI_PAT_E = 4'hE;
    localparam logic [3:0] NBI_PAT_C = 4'hC;
    localparam logic [3:0] NBI_PAT_A = 4'hA;
    localparam logic [3:0] NBI_PAT_8 = 4'h8;
    localparam logic [3:0] NBI_PAT_2X = 4'h2;
    localparam logic [3:0] NBI_PAT_2X_MASK = 4'hE;
    localparam logic [3:0] NBI_PAT_ZERO = 4'h0;

    // values after reset
    localparam logic [7:0] NBI_REG_RST = 8'h00;
    localparam logic [31:0] NBI_RDATA_RST = 32'h0000_0000;
    localparam logic [2:0] NBI_VOTE_HIST_RST = 3'h7;

    // national bit 7 vote: zeros needed out of the window
    localparam int NBI_VOTE_DEPTH = 3;
    localparam int NBI_VOTE_MIN = 2;

    // apb slave phase
    typedef enum logic [1:0] {
        NBI_IDLE = 2'b01,
        NBI_ACC = 2'b10
    } nbi_apb_e;

endpackage

// *** hw/nbi_vote.sv ***
`timescale 1ns/10ps
`default_nettype none
module nbi_vote
    import nbi_pkg::*;
#(
    parameter int DEPTH = NBI_VOTE_DEPTH,
    parameter int MIN_ZEROS = NBI_VOTE_MIN
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // received national bit 7 occurrences
    input wire logic bit_in,
    input wire logic bit_stb,
    // voted result
    output logic zero_ff
);

    logic [DEPTH-1:0] hist_ff;
    logic [DEPTH-1:0] nxt_hist;
    logic nxt_zero;

    // count zeros in a window; a loop so the depth can change freely
    function automatic int nbi_zeros(input logic [DEPTH-1:0] h);
        int n;
        n = 0;
        for (int i = 0; i < DEPTH; i++) begin
            if (!h[i]) begin
                n = n + 1;
            end
        end
        return n;
    endfunction

    // history starts all ones so reset never declares the state
    assign nxt_hist = {hist_ff[DEPTH-2:0], bit_in};
    assign nxt_zero = (nbi_zeros(nxt_hist) >= MIN_ZEROS);

    // only a strobe advances the window
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hist_ff <= DEPTH'(NBI_VOTE_HIST_RST);
            zero_ff <= 1'b0;
        end else if (bit_stb) begin
            hist_ff <= nxt_hist;
            zero_ff <= nxt_zero; // R10
        end
    end

endmodule
`default_nettype wire

// *** hw/nbi_top.sv ***
// How it works
// R1: enable bit 7 flags entering/leaving 1111
// R2: enable bit 6 flags entering/leaving 1110
// R3: enable bit 5 flags entering/leaving 1100
// R4: enable bit 4 flags entering/leaving 1010
// R5: enable bit 3 flags entering/leaving 1000
// R6: enable bit 2 flags 001x, low bit ignored
// R7: enable bit 1 flags unlisted pattern
// R8: enable bit 0 flags entering/leaving 0000
// R9: enable bits read/write, zero blocks interrupt
// R10: state bit 5 set on 2-of-3 zeros
// R11: status bit 1 on state set or cleared
// R12: status bit 0 on zero-run change
// R13: status bits stick until read, then clear
// R14: sa6 status bits mirror enable positions
// R15: interrupt high while enabled status set
`timescale 1ns/10ps
`default_nettype none
module nbi_top
    import nbi_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [NBI_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive framer core, same clock
    input wire logic [3:0] sa6_dbn,
    input wire logic sa7_rx,
    input wire logic sa7_stb,
    input wire logic exz_cond,
    // interrupt
    output logic irq
);

    nbi_apb_e apb_st_ff;
    nbi_apb_e nxt_apb_st;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic nxt_irq;

    // register decode latched in setup for use at the access edge
    logic hit_sa_isr_ff;
    logic hit_sa_ier_ff;
    logic hit_exz_sr_ff;
    logic hit_exz_er_ff;
    logic dec_sa_isr;
    logic dec_sa_ier;
    logic dec_exz_sr;
    logic dec_exz_er;
    logic dec_any;
    logic setup;
    logic done;
    logic rd_done;
    logic wr_done;
    logic [31:0] rd_mux;

    // software registers
    logic [7:0] sa_isr_ff;
    logic [7:0] sa_ier_ff;
    logic [7:0] exz_sr_ff;
    logic [7:0] exz_er_ff;
    logic [7:0] nxt_sa_isr;
    logic [7:0] nxt_exz_sr;
    logic [7:0] sa_clr;
    logic [7:0] exz_clr;

    // event detection
    logic primed_ff;
    logic [7:0] sa6_prev_ff;
    logic [7:0] sa6_cls;
    logic [7:0] sa6_chg;
    logic nat7_zero_state;
    logic nat7_prev_ff;
    logic zrun_prev_ff;
    logic nat7_chg;
    logic zrun_chg;
    logic [7:0] exz_set;

    // map a debounced nibble onto the status bit layout
    function automatic logic [7:0] nbi_classify(input logic [3:0] v);
        logic [7:0] c;
        c = NBI_REG_RST;
        c[NBI_SA6_ONES_BIT] = (v == NBI_PAT_ONES); // R1
        c[NBI_SA6_E_BIT] = (v == NBI_PAT_E); // R2
        c[NBI_SA6_C_BIT] = (v == NBI_PAT_C); // R3
        c[NBI_SA6_A_BIT] = (v == NBI_PAT_A); // R4
        c[NBI_SA6_8_BIT] = (v == NBI_PAT_8); // R5
        c[NBI_SA6_2X_BIT] = ((v & NBI_PAT_2X_MASK) == NBI_PAT_2X); // R6
        c[NBI_SA6_ZERO_BIT] = (v == NBI_PAT_ZERO); // R8
        c[NBI_SA6_UNL_BIT] = (c == NBI_REG_RST); // R7
        return c;
    endfunction

    // decode one aligned word address
    function automatic logic nbi_hit(
        input logic [NBI_ADDR_W-1:0] a,
        input logic [NBI_ADDR_W-1:0] ofs
    );
        return (a == ofs);
    endfunction

    // outputs straight from flops
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;

    // apb phase qualifiers
    assign setup = psel && !penable;
    assign done = psel && penable && pready_ff;
    assign rd_done = done && !pwrite;
    assign wr_done = done && pwrite;

    // address decode, unaligned addresses never match
    assign dec_sa_isr = nbi_hit(paddr, NBI_SA_ISR_OFS);
    assign dec_sa_ier = nbi_hit(paddr, NBI_SA_IER_OFS);
    assign dec_exz_sr = nbi_hit(paddr, NBI_EXZ_SR_OFS);
    assign dec_exz_er = nbi_hit(paddr, NBI_EXZ_ER_OFS);
    assign dec_any = dec_sa_isr | dec_sa_ier | dec_exz_sr | dec_exz_er;

    // read data, upper bits zero, reserved bits zero
    always_comb begin
        rd_mux = NBI_RDATA_RST;
        if (dec_sa_isr) begin
            rd_mux[7:0] = sa_isr_ff;
        end else if (dec_sa_ier) begin
            rd_mux[7:0] = sa_ier_ff; // R9
        end else if (dec_exz_sr) begin
            rd_mux[7:0] = exz_sr_ff;
            rd_mux[NBI_NAT7_STATE_BIT] = nat7_zero_state; // R10
        end else if (dec_exz_er) begin
            rd_mux[7:0] = exz_er_ff;
        end
    end

    // apb phase tracker: setup always answers in the next cycle
    always_comb begin
        nxt_apb_st = apb_st_ff;
        unique case (apb_st_ff)
            NBI_IDLE: begin
                if (setup) begin
                    nxt_apb_st = NBI_ACC;
                end
            end
            NBI_ACC: begin
                nxt_apb_st = NBI_IDLE;
            end
            default: begin
                nxt_apb_st = NBI_IDLE;
            end
        endcase
    end

    // state and ready; zero wait states keep the slave simple
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            apb_st_ff <= NBI_IDLE;
            pready_ff <= 1'b0;
        end else begin
            apb_st_ff <= nxt_apb_st;
            pready_ff <= (nxt_apb_st == NBI_ACC);
        end
    end

    // read data and error captured in setup, shown in access only;
    // cleared at the access edge so the bus reads zero between transfers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff <= NBI_RDATA_RST;
            pslverr_ff <= 1'b0;
            hit_sa_isr_ff <= 1'b0;
            hit_sa_ier_ff <= 1'b0;
            hit_exz_sr_ff <= 1'b0;
            hit_exz_er_ff <= 1'b0;
        end else if (setup) begin
            prdata_ff <= pwrite ? NBI_RDATA_RST : rd_mux;
            pslverr_ff <= !dec_any;
            hit_sa_isr_ff <= dec_sa_isr;
            hit_sa_ier_ff <= dec_sa_ier;
            hit_exz_sr_ff <= dec_exz_sr;
            hit_exz_er_ff <= dec_exz_er;
        end else begin
            prdata_ff <= NBI_RDATA_RST;
            pslverr_ff <= 1'b0;
        end
    end

    // enable registers take write data at the access edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sa_ier_ff <= NBI_REG_RST;
            exz_er_ff <= NBI_REG_RST;
        end else if (wr_done) begin
            if (hit_sa_ier_ff) begin
                sa_ier_ff <= pwdata[7:0]; // R9
            end
            if (hit_exz_er_ff) begin
                exz_er_ff <= pwdata[7:0] & NBI_EXZ_ER_MASK;
            end
        end
    end

    // the first cycle after reset only loads history, so a pattern
    // already present at reset does not look like a change
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            primed_ff <= 1'b0;
            sa6_prev_ff <= NBI_REG_RST;
            zrun_prev_ff <= 1'b0;
        end else begin
            primed_ff <= 1'b1;
            sa6_prev_ff <= sa6_cls;
            zrun_prev_ff <= exz_cond;
        end
    end

    // voter state starts undeclared, so its history needs no priming
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nat7_prev_ff <= 1'b0;
        end else begin
            nat7_prev_ff <= nat7_zero_state;
        end
    end

    // national bit 7 two-of-three vote
    nbi_vote #(
        .DEPTH(NBI_VOTE_DEPTH),
        .MIN_ZEROS(NBI_VOTE_MIN)
    ) u_vote (
        .mclk(mclk),
        .rst_n(rst_n),
        .bit_in(sa7_rx),
        .bit_stb(sa7_stb),
        .zero_ff(nat7_zero_state)
    );

    // sa6 events: both edges for listed patterns, entry only for unlisted
    assign sa6_cls = nbi_classify(sa6_dbn);
    always_comb begin
        sa6_chg = NBI_REG_RST;
        if (primed_ff) begin
            sa6_chg = ((sa6_cls ^ sa6_prev_ff) & ~NBI_SA6_UNL_MASK) // R14
                | (sa6_cls & ~sa6_prev_ff & NBI_SA6_UNL_MASK); // R7
        end
    end

    // national bit 7 and zero-run change events
    assign nat7_chg = nat7_zero_state ^ nat7_prev_ff; // R11
    assign zrun_chg = primed_ff && (exz_cond ^ zrun_prev_ff); // R12
    always_comb begin
        exz_set = NBI_REG_RST;
        exz_set[NBI_NAT7_CHG_BIT] = nat7_chg;
        exz_set[NBI_ZRUN_CHG_BIT] = zrun_chg;
    end

    // a read clears only the bits it returned; a bit set after the
    // setup cycle survives the read and shows on the next one
    assign sa_clr = (rd_done && hit_sa_isr_ff) ? prdata_ff[7:0] : NBI_REG_RST;
    assign exz_clr = (rd_done && hit_exz_sr_ff) ?
        (prdata_ff[7:0] & NBI_EXZ_STICKY_MASK) : NBI_REG_RST;

    // sticky status, set wins over the read clear
    assign nxt_sa_isr = (sa_isr_ff & ~sa_clr) | sa6_chg; // R13
    assign nxt_exz_sr = ((exz_sr_ff & ~exz_clr) | exz_set)
        & NBI_EXZ_STICKY_MASK; // R13

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sa_isr_ff <= NBI_REG_RST;
            exz_sr_ff <= NBI_REG_RST;
        end else begin
            sa_isr_ff <= nxt_sa_isr;
            exz_sr_ff <= nxt_exz_sr;
        end
    end

    // interrupt from current status, one flop behind it
    assign nxt_irq = (|(sa_isr_ff & sa_ier_ff)) // R9
        | (|(exz_sr_ff & exz_er_ff)); // R15

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq; // R15
        end
    end

endmodule
`default_nettype wire

// *** tb/nbi_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module nbi_checker
    import nbi_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [NBI_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // framer side and interrupt
    input wire logic [3:0] sa6_dbn,
    input wire logic exz_cond,
    input wire logic irq
);
    logic [7:0] ier_ff;
    logic [1:0] eer_ff;
    logic wr;
    logic map;
    logic en_any;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // decode of completed writes and of the mapped places
    assign wr = psel && penable && pready && pwrite;
    assign map = paddr inside {NBI_SA_ISR_OFS, NBI_SA_IER_OFS,
        NBI_EXZ_SR_OFS, NBI_EXZ_ER_OFS};
    assign en_any = |ier_ff || |eer_ff;
    // shadow enables, so irq checks know what software allowed
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ier_ff <= 8'h00;
            eer_ff <= 2'h0;
        end else if (wr && paddr == NBI_SA_IER_OFS) begin
            ier_ff <= pwdata[7:0];
        end else if (wr && paddr == NBI_EXZ_ER_OFS) begin
            eer_ff <= pwdata[1:0];
        end
    end
    AST_RDY_NEXT: assert property (psel && !penable |=> pready)
        else $error("setup not answered next cycle");
    AST_RDY_ONE: assert property (pready |=> !pready)
        else $error("ready held beyond access");
    AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    AST_ERR_MAP: assert property (pready |-> pslverr == !map)
        else $error("error flag wrong for address");
    AST_IER_RD: assert property (
        pready && !pwrite && paddr == NBI_SA_IER_OFS
        |-> prdata[7:0] == ier_ff) else $error("enable readback wrong");
    AST_CLR_IRQ: assert property ($fell(irq) |-> $past(pready, 2))
        else $error("irq fell without access");
    AST_ONES_IRQ: assert property (
        ier_ff[NBI_SA6_ONES_BIT] && (($past(sa6_dbn) == NBI_PAT_ONES)
        != (sa6_dbn == NBI_PAT_ONES)) |-> ##2 irq)
        else $error("ones change gave no irq");
    AST_EXZ_IRQ: assert property (
        eer_ff[NBI_ZRUN_CHG_BIT] && $changed(exz_cond) |-> ##2 irq)
        else $error("zero run change gave no irq");
    AST_QUIET: assert property (
        !en_any && !$past(en_any) && !$past(en_any, 2) |-> !irq)
        else $error("irq with all enables off");
    cover property (wr && paddr == NBI_SA_IER_OFS);
    cover property ($rose(irq));
    cover property (pready && pslverr);
endmodule
bind nbi_top nbi_checker u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sa6_dbn(sa6_dbn), .exz_cond(exz_cond), .irq(irq));
`default_nettype wire

// *** tb/e1_national_bit_interrupts_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module e1_national_bit_interrupts_test
    import nbi_pkg::*;
;
    localparam logic [3:0] SEQ [9] = '{4'hE, 4'hC, 4'hA, 4'h8, 4'h2,
        4'h3, 4'h5, 4'h7, 4'h0};
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, sa7_rx = 1'b0, sa7_stb = 1'b0, exz_cond = 1'b0;
    logic [NBI_ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [3:0] sa6_dbn = 4'h0;
    logic [3:0] prev;
    logic [7:0] r;
    logic [32:0] expq[$];
    int num_errors = 0, samples_checked = 0, cyc = 0;

    nbi_top dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sa6_dbn(sa6_dbn), .sa7_rx(sa7_rx), .sa7_stb(sa7_stb),
        .exz_cond(exz_cond), .irq(irq));

    // 200 mhz clock
    initial begin
        forever #2.5 mclk = ~mclk;
    end

    task chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task results;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // one apb transfer, then an idle cycle so no signal is set twice
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // one sa7 occurrence; the line toggles away between strobes
    task nat(input logic b);
        sa7_rx <= b;
        sa7_stb <= 1'b1;
        @(posedge mclk);
        sa7_stb <= 1'b0;
        sa7_rx <= ~b;
        wt(3);
    endtask

    function automatic logic [7:0] cls(input logic [3:0] v);
        case (v)
            4'hF: return 8'h80;
            4'hE: return 8'h40;
            4'hC: return 8'h20;
            4'hA: return 8'h10;
            4'h8: return 8'h08;
            4'h2, 4'h3: return 8'h04;
            4'h0: return 8'h01;
            default: return 8'h02;
        endcase
    endfunction

    // unlisted values flag on entry only, so leaving drops bit 1
    function automatic logic [7:0] evt(input logic [3:0] o,
        input logic [3:0] n);
        if (cls(o) == cls(n))
            return 8'h00;
        return (cls(o) & 8'hFD) | cls(n);
    endfunction

    // read watcher, plus the hang limit
    always @(posedge mclk) begin
        cyc++;
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata}, expq.pop_front());
        if (cyc > 5000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        void'($urandom(98));
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        wt(2);
        bus(1'b1, NBI_SA_ISR_OFS, 32'h0000_00FF);
        rd(NBI_SA_ISR_OFS, 33'h0);
        rd(NBI_SA_IER_OFS, 33'h0);
        rd(NBI_EXZ_SR_OFS, 33'h0);
        rd(NBI_EXZ_ER_OFS, 33'h0);
        rd(12'hB1C, 33'h1_0000_0000);
        rd(12'hB0D, 33'h1_0000_0000);
        $display("test 1 done");
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom);
            bus(1'b1, NBI_SA_IER_OFS, {24'h0, r});
            rd(NBI_SA_IER_OFS, {25'h0, r});
            bus(1'b1, NBI_EXZ_ER_OFS, {24'h0, r});
            rd(NBI_EXZ_ER_OFS, {31'h0, r[1:0]});
        end
        $display("test 2 done");
        bus(1'b1, NBI_SA_IER_OFS, 32'h0000_007E);
        sa6_dbn <= 4'hF;
        wt(4);
        chk(irq, 1'b0);
        rd(NBI_SA_ISR_OFS, 33'h81);
        bus(1'b1, NBI_SA_IER_OFS, 32'h0000_00FF);
        $display("test 3 done");
        for (int i = 0; i < 9; i++) begin
            prev = sa6_dbn;
            sa6_dbn <= SEQ[i];
            wt(4);
            chk(irq, evt(prev, SEQ[i]) != 8'h00);
            rd(NBI_SA_ISR_OFS,
                {25'h0, evt(prev, SEQ[i])});
            wt(2);
            chk(irq, 1'b0);
        end
        $display("test 4 done");
        bus(1'b1, NBI_EXZ_ER_OFS, 32'h0000_0003);
        nat(1'b0);
        nat(1'b0);
        rd(NBI_EXZ_SR_OFS, 33'h22);
        nat(1'b1);
        rd(NBI_EXZ_SR_OFS, 33'h20);
        nat(1'b1);
        rd(NBI_EXZ_SR_OFS, 33'h02);
        $display("test 5 done");
        exz_cond <= 1'b1;
        wt(4);
        chk(irq, 1'b1);
        rd(NBI_EXZ_SR_OFS, 33'h01);
        exz_cond <= 1'b0;
        wt(4);
        rd(NBI_EXZ_SR_OFS, 33'h01);
        rd(NBI_EXZ_SR_OFS, 33'h00);
        $display("test 6 done");
        results();
    end
endmodule
`default_nettype wire
